// ==== rtl/mdfs_top.sv ====
// Mode, fault and serial-address supervisor of a brushed DC motor bridge
// Assumes analog detectors, pins and serial lines are asynchronous to sys_clk;
// software bits come from logic on sys_clk; rst_b is the undervoltage reset
`include "mdfs_regs.svh"
module mdfs_top
  import mdfs_pkg::*;
#(
  parameter int WAKE_CYC  = `MDFS_WAKE_DELAY_US * `MDFS_CLK_MHZ,
  parameter int SLEEP_CYC = `MDFS_SLEEP_ENTRY_DELAY_US * `MDFS_CLK_MHZ,
  parameter int RETRY_CYC = `MDFS_RETRY_INTERVAL_US * `MDFS_CLK_MHZ
) (
  input  logic       sys_clk,
  input  logic       rst_b,
  input  logic       sleep_input_n,
  input  mdfs_det_t  detect_in,
  input  logic [1:0] addr_select_upper_pin,
  input  logic [1:0] addr_select_lower_pin,
  input  logic       output_enable,
  input  logic       overcurrent_response_select,
  input  logic       thermal_response_select,
  input  logic       fault_clear_cmd,
  input  logic       ovp_en_wr,
  input  logic       ovp_en_wdata,
  input  logic       scl_in,
  input  logic       sda_in,
  output logic       sda_out,
  output logic       sda_oe_n,
  output logic       fault_out_n_out,
  output logic       fault_out_n_oe_n,
  output logic       bridge_enable,
  output logic       lowside_brake,
  output logic       overvoltage_brake_enable,
  output mdfs_stat_t status,
  output logic [3:0] addr_code
);
  // -----------------------------------------------------------------
  // Synchronisers
  // -----------------------------------------------------------------
  logic [11:0] meta_r;
  logic [11:0] sync_r;
  logic        scl_d_r;
  logic        sda_d_r;
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      // Detectors and sleep pin idle low, serial lines idle high: no false event after reset
      meta_r  <= 12'h007;
      sync_r  <= 12'h007;
      scl_d_r <= 1'h1;
      sda_d_r <= 1'h1;
    end else begin
      meta_r  <= {addr_select_upper_pin, addr_select_lower_pin, detect_in, sleep_input_n,
                  scl_in, sda_in, 1'h1};
      sync_r  <= meta_r;
      scl_d_r <= sync_r[2];
      sda_d_r <= sync_r[1];
    end
  end
  mdfs_det_t   det_s;
  logic        sleep_n_s;
  logic        scl_s;
  logic        sda_s;
  logic [1:0]  up_s;
  logic [1:0]  lo_s;
  assign up_s      = sync_r[11:10];
  assign lo_s      = sync_r[9:8];
  assign det_s     = sync_r[7:4];
  assign sleep_n_s = sync_r[3];
  assign scl_s     = sync_r[2];
  assign sda_s     = sync_r[1];

  // Three-level pin code; an undefined level reads as open
  function automatic logic [3:0] pin_lvl(input logic [1:0] p);
    pin_lvl = (p == `MDFS_PIN_HIGH) ? 4'h2 : (p == `MDFS_PIN_LOW) ? 4'h0 : 4'h1;
  endfunction

  // -----------------------------------------------------------------
  // Modes and faults
  // -----------------------------------------------------------------
  mdfs_mode_t mode_r, mode_nxt;
  logic [19:0] mcnt_r, mcnt_nxt;
  logic [19:0] rcnt_r, rcnt_nxt;
  logic oc_r, oc_nxt, ot_r, ot_nxt, ots_r, ots_nxt, ov_r, ov_nxt;
  logic hct_r, hct_nxt, brk_r, brk_nxt, ovpe_r, ovpe_nxt;
  logic bren_r, flt_oe_n_r, flt_r;
  logic [1:0] cap_r, cap_nxt;
  logic [3:0] code_r, code_nxt;
  logic awake, oc_set, ot_set, ot_clr, oc_clr, hiz;

  always_comb begin
    mode_nxt = mode_r;
    mcnt_nxt = mcnt_r;
    rcnt_nxt = 20'h0_0000;
    awake    = (mode_r == M_IDLE) || (mode_r == M_ACTIVE) || (mode_r == M_FAULT);
    // Overcurrent is only sensed while the bridge drives
    oc_set   = (mode_r == M_ACTIVE) && det_s.oc;
    ot_set   = awake && det_s.ot;
    oc_clr   = 1'h0;
    ot_clr   = thermal_response_select ? 1'h1 : fault_clear_cmd;
    if (overcurrent_response_select) begin
      if (oc_r) begin
        rcnt_nxt = rcnt_r + 20'h0_0001;
        oc_clr   = (rcnt_r == 20'(RETRY_CYC - 1));
      end
    end else begin
      oc_clr = fault_clear_cmd;
    end
    // Set wins over clear so an event in the clear cycle survives
    oc_nxt   = oc_set || (oc_r && !oc_clr);
    ot_nxt   = ot_set || (ot_r && !ot_clr);
    ots_nxt  = ot_set || (ots_r && !fault_clear_cmd);
    case (mode_r)
      M_SLEEP: begin
        mcnt_nxt = 20'h0_0000;
        if (sleep_n_s) begin
          mode_nxt = M_WAKE;
        end
      end
      M_WAKE: begin
        mcnt_nxt = mcnt_r + 20'h0_0001;
        if (!sleep_n_s) begin
          mode_nxt = M_SLEEP;
        end else if (mcnt_r == 20'(WAKE_CYC - 1)) begin
          mode_nxt = M_IDLE;
          mcnt_nxt = 20'h0_0000;
        end
      end
      M_IDLE: begin
        if (oc_nxt || ot_nxt) begin
          mode_nxt = M_FAULT;
        end else if (output_enable && sleep_n_s) begin
          mode_nxt = M_ACTIVE;
        end
      end
      M_ACTIVE: begin
        if (oc_nxt || ot_nxt) begin
          mode_nxt = M_FAULT;
        end else if (!output_enable) begin
          mode_nxt = M_IDLE;
        end
      end
      M_FAULT: begin
        if (!oc_nxt && !ot_nxt) begin
          mode_nxt = (output_enable && sleep_n_s) ? M_ACTIVE : M_IDLE;
        end
      end
      default: mode_nxt = M_SLEEP;
    endcase
    if (awake) begin
      mcnt_nxt = sleep_n_s ? 20'h0_0000 : mcnt_r + 20'h0_0001;
      if (!sleep_n_s && (mcnt_r == 20'(SLEEP_CYC - 1))) begin
        mode_nxt = M_SLEEP;
        mcnt_nxt = 20'h0_0000;
      end
    end
    // Sleep resets the fault logic but not the brake enable
    if (mode_nxt == M_SLEEP) begin
      oc_nxt  = 1'h0;
      ot_nxt  = 1'h0;
      ots_nxt = 1'h0;
    end
    hiz      = (mode_nxt != M_ACTIVE);
    // overvoltage status only when high impedance
    ov_nxt   = det_s.ov && hiz;
    hct_nxt  = det_s.ov && (hct_r || ((mode_r == M_SLEEP) && det_s.hc));
    ovpe_nxt = ovp_en_wr ? ovp_en_wdata : ovpe_r;
    brk_nxt  = hiz && ovpe_r && det_s.ov && !hct_nxt;
    cap_nxt  = (cap_r == 2'h3) ? cap_r : cap_r + 2'h1;
    code_nxt = (cap_r == 2'h2) ? 4'(3 * pin_lvl(up_s) + pin_lvl(lo_s)) : code_r;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      mode_r     <= M_SLEEP;
      mcnt_r     <= 20'h0_0000;
      rcnt_r     <= 20'h0_0000;
      oc_r       <= 1'h0;
      ot_r       <= 1'h0;
      ots_r      <= 1'h0;
      ov_r       <= 1'h0;
      hct_r      <= 1'h0;
      brk_r      <= 1'h0;
      // brake enable only reset by power-up
      ovpe_r     <= `MDFS_OVP_EN_RST;
      bren_r     <= 1'h0;
      flt_oe_n_r <= 1'h1;
      flt_r      <= 1'h0;
      cap_r      <= 2'h0;
      code_r     <= 4'h0;
    end else begin
      mode_r     <= mode_nxt;
      mcnt_r     <= mcnt_nxt;
      rcnt_r     <= rcnt_nxt;
      oc_r       <= oc_nxt;
      ot_r       <= ot_nxt;
      ots_r      <= ots_nxt;
      ov_r       <= ov_nxt;
      hct_r      <= hct_nxt;
      brk_r      <= brk_nxt;
      ovpe_r     <= ovpe_nxt;
      bren_r     <= (mode_nxt == M_ACTIVE);
      flt_oe_n_r <= !(oc_nxt || ot_nxt);
      flt_r      <= oc_nxt || ot_nxt;
      cap_r      <= cap_nxt;
      code_r     <= code_nxt;
    end
  end

  // -----------------------------------------------------------------
  // Serial follower
  // -----------------------------------------------------------------
  mdfs_i2c_t i2c_r, i2c_nxt;
  logic [7:0] rx_r, rx_nxt, tx_r, tx_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic rw_r, rw_nxt, sda_oe_n_r, sda_oe_n_nxt;
  logic scl_rise, scl_fall, start, stop, match;
  logic [7:0] st_byte;

  always_comb begin
    st_byte                 = 8'h00;
    st_byte[`MDFS_ST_FAULT] = oc_r || ot_r;
    st_byte[`MDFS_ST_OCP]   = oc_r;
    st_byte[`MDFS_ST_OVP]   = ov_r;
    st_byte[`MDFS_ST_TSD]   = ots_r;
    scl_rise     = scl_s && !scl_d_r;
    scl_fall     = !scl_s && scl_d_r;
    start        = scl_s && scl_d_r && sda_d_r && !sda_s;
    stop         = scl_s && scl_d_r && !sda_d_r && sda_s;
    // general call address 0 never matches a nonzero base
    match        = ({rx_r[7:1], 1'h0} == 8'(`MDFS_ADDR_BASE + {code_r, 1'h0}))
                   && (rx_r[7:1] != 7'h00);
    i2c_nxt      = i2c_r;
    rx_nxt       = rx_r;
    tx_nxt       = tx_r;
    bit_nxt      = bit_r;
    rw_nxt       = rw_r;
    sda_oe_n_nxt = sda_oe_n_r;
    if (scl_rise && ((i2c_r == I_ADDR) || (i2c_r == I_RX))) begin
      rx_nxt  = {rx_r[6:0], sda_s};
      bit_nxt = bit_r + 4'h1;
    end
    if (scl_rise && (i2c_r == I_TX)) begin
      bit_nxt = bit_r + 4'h1;
    end
    if (scl_fall) begin
      case (i2c_r)
        I_ADDR, I_RX: begin
          if (bit_r == 4'h8) begin
            if ((i2c_r == I_RX) || match) begin
              i2c_nxt      = (i2c_r == I_RX) ? I_DACK : I_AACK;
              rw_nxt       = (i2c_r == I_RX) ? rw_r : rx_r[0];
              sda_oe_n_nxt = 1'h0;
            end else begin
              i2c_nxt = I_IDLE;
            end
          end
        end
        I_AACK, I_MACK: begin
          bit_nxt = 4'h0;
          if (rw_r) begin
            i2c_nxt      = I_TX;
            tx_nxt       = {st_byte[6:0], 1'h0};
            sda_oe_n_nxt = st_byte[7];
          end else begin
            i2c_nxt      = I_RX;
            sda_oe_n_nxt = 1'h1;
          end
        end
        I_DACK: begin
          i2c_nxt      = I_RX;
          bit_nxt      = 4'h0;
          sda_oe_n_nxt = 1'h1;
        end
        I_TX: begin
          if (bit_r == 4'h8) begin
            i2c_nxt      = I_MACK;
            sda_oe_n_nxt = 1'h1;
          end else begin
            sda_oe_n_nxt = tx_r[7];
            tx_nxt       = {tx_r[6:0], 1'h0};
          end
        end
        default: i2c_nxt = i2c_r;
      endcase
    end
    // Leader NACK ends the read
    if (scl_rise && (i2c_r == I_MACK) && sda_s) begin
      i2c_nxt = I_IDLE;
    end
    if (start) begin
      i2c_nxt      = I_ADDR;
      bit_nxt      = 4'h0;
      sda_oe_n_nxt = 1'h1;
    end else if (stop) begin
      i2c_nxt      = I_IDLE;
      sda_oe_n_nxt = 1'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      i2c_r      <= I_IDLE;
      rx_r       <= 8'h00;
      tx_r       <= 8'h00;
      bit_r      <= 4'h0;
      rw_r       <= 1'h0;
      sda_oe_n_r <= 1'h1;
    end else begin
      i2c_r      <= i2c_nxt;
      rx_r       <= rx_nxt;
      tx_r       <= tx_nxt;
      bit_r      <= bit_nxt;
      rw_r       <= rw_nxt;
      sda_oe_n_r <= sda_oe_n_nxt;
    end
  end

  logic od_low_r;
  always_ff @(posedge sys_clk) begin
    od_low_r <= 1'h0;
  end
  assign sda_out                  = od_low_r;
  assign fault_out_n_out          = od_low_r;
  assign fault_out_n_oe_n         = flt_oe_n_r;
  assign sda_oe_n                 = sda_oe_n_r;
  assign bridge_enable            = bren_r;
  assign lowside_brake            = brk_r;
  assign overvoltage_brake_enable = ovpe_r;
  assign status                   = {flt_r, oc_r, ov_r, ots_r};
  assign addr_code                = code_r;

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  a_fault_pin_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (mode_r == M_FAULT) |-> !flt_oe_n_r) else $error("fault mode with pin released");
  a_ovp_pin_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ov_r && !oc_r && !ot_r) |-> flt_oe_n_r) else $error("overvoltage drove fault pin");
  a_bridge_off_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (mode_r != M_ACTIVE) |-> !bren_r) else $error("bridge on outside active");
  a_active_entry: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(bren_r) |-> $past(output_enable) && $past(sleep_n_s)) else $error("bad active entry");
  a_brake_gated: assert property (@(posedge sys_clk) disable iff (!rst_b)
    brk_r |-> $past(ovpe_r) && !bren_r && $past(det_s.ov)) else $error("brake without cause");
  a_ovp_en_reset: assert property (@(posedge sys_clk)
    (!$past(rst_b) && rst_b) |-> ovpe_r) else $error("brake enable not set at reset");
  a_ot_sticky: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ots_r && !fault_clear_cmd && mode_nxt != M_SLEEP) |=> ots_r) else $error("status lost");
  a_addr_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cap_r == 2'h3) |=> $stable(code_r)) else $error("address code changed");
  a_ack_match: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(i2c_r == I_AACK) |-> $past(match) && !sda_oe_n_r) else $error("ack without match");
  a_retry_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ($rose(oc_r) && overcurrent_response_select) |-> !bren_r[*8]) else $error("retry too short");
  a_sleep_hc_cut: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (mode_r == M_SLEEP && det_s.hc && det_s.ov) |=> !brk_r) else $error("brake kept on short");
endmodule

// ==== rtl/mdfs_regs.svh ====
// Constants of the motor driver mode and fault supervisor
// Assumes a single 25 MHz system clock; included by the top module only
`ifndef MDFS_REGS_SVH
`define MDFS_REGS_SVH
// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define MDFS_CLK_MHZ               25
`define MDFS_WAKE_DELAY_US         1000
`define MDFS_SLEEP_ENTRY_DELAY_US  1000
`define MDFS_RETRY_INTERVAL_US     1000
// -----------------------------------------------------------------
// Reset values, address and status byte layout
// -----------------------------------------------------------------
`define MDFS_OVP_EN_RST            1'h1
`define MDFS_ADDR_BASE             8'h60
`define MDFS_PIN_LOW               2'h0
`define MDFS_PIN_OPEN              2'h1
`define MDFS_PIN_HIGH              2'h2
`define MDFS_ST_FAULT              7
`define MDFS_ST_OCP                4
`define MDFS_ST_OVP                3
`define MDFS_ST_TSD                2
`endif

// ==== rtl/mdfs_pkg.sv ====
// Types of the motor driver mode and fault supervisor
// Assumes nothing beyond a SystemVerilog compiler
package mdfs_pkg;
  // Analog comparator outputs from the power stage
  typedef struct packed {
    logic oc;
    logic ot;
    logic ov;
    logic hc;
  } mdfs_det_t;
  // Status as seen by the serial leader
  typedef struct packed {
    logic fault;
    logic overcurrent_protect;
    logic overvoltage_brake;
    logic thermal_shutdown;
  } mdfs_stat_t;
  typedef enum logic [2:0] {M_SLEEP, M_WAKE, M_IDLE, M_ACTIVE, M_FAULT} mdfs_mode_t;
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_AACK, I_TX, I_MACK, I_RX, I_DACK} mdfs_i2c_t;
endpackage

// ==== bench/mdfs_leader.sv ====
// Serial leader model that clocks and frames transfers to the follower
// Assumes pull-ups on both lines; the follower drives its data output when its enable is low
module mdfs_leader (
  output logic scl,
  output logic sda,
  input  logic dut_oe_n,
  input  logic dut_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lead_low;
  // Wired-AND with pull-up: released line reads high, never a stale value
  assign sda = !lead_low && (dut_oe_n || dut_out);
  initial begin
    scl      = 1'b1;
    lead_low = 1'b0;
  end
  // ---------------------------------------------------------------
  // Frame tasks
  // ---------------------------------------------------------------
  // leader makes start condition
  task automatic start();
    #7 lead_low = 1'b0;
    scl = 1'b1;
    #80 lead_low = 1'b1;
    #80 scl = 1'b0;
  endtask
  task automatic stop();
    #40 lead_low = 1'b1;
    #40 scl = 1'b1;
    #80 lead_low = 1'b0;
    #80;
  endtask
  // leader clocks every bit
  // Sample mid high phase: follower data lags SCL fall by its sync delay
  task automatic bit_io(input logic b, output logic r);
    lead_low = !b;
    #80 scl = 1'b1;
    #80 r = sda;
    #80 scl = 1'b0;
    #80;
  endtask
  task automatic byte_io(input  logic [7:0] tx,
                         input  logic       ab,
                         output logic [7:0] rx,
                         output logic       ar);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ab, ar);
  endtask
endmodule

// ==== bench/test_mdfs_top.sv ====
// Self-checking bench of the mode, fault and serial address supervisor
// Assumes the leader model on the serial lines; short delays keep the run brief
module test_mdfs_top
  import mdfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WAKE = 40;
  localparam int SLP  = 40;
  localparam int RTY  = 40;
  logic       sys_clk;
  logic       rst_b;
  logic       sleep_input_n;
  logic       oe;
  logic       oc_sel;
  logic       tsd_sel;
  logic       clr;
  logic       bwr;
  logic       bwd;
  logic       scl;
  logic       sda;
  logic       sda_out;
  logic       sda_oe_n;
  logic       flt_out;
  logic       flt_oe_n;
  logic       fault_pin;
  logic       bridge;
  logic       brake;
  logic       brake_en;
  logic       ar;
  logic [1:0] up_pin;
  logic [1:0] lo_pin;
  logic [3:0] addr_code;
  logic [7:0] rx;
  mdfs_det_t  det;
  mdfs_stat_t status;
  int         bad_count;
  int         check_count;
  // Pull-up on the fault pin
  assign fault_pin = flt_oe_n ? 1'b1 : flt_out;
  mdfs_top #(.WAKE_CYC(WAKE), .SLEEP_CYC(SLP), .RETRY_CYC(RTY)) i_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .sleep_input_n(sleep_input_n), .detect_in(det),
    .addr_select_upper_pin(up_pin), .addr_select_lower_pin(lo_pin), .output_enable(oe),
    .overcurrent_response_select(oc_sel), .thermal_response_select(tsd_sel),
    .fault_clear_cmd(clr), .ovp_en_wr(bwr), .ovp_en_wdata(bwd), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .fault_out_n_out(flt_out),
    .fault_out_n_oe_n(flt_oe_n), .bridge_enable(bridge), .lowside_brake(brake),
    .overvoltage_brake_enable(brake_en), .status(status), .addr_code(addr_code));
  mdfs_leader i_lead (.scl(scl), .sda(sda), .dut_oe_n(sda_oe_n), .dut_out(sda_out));
  always #20 sys_clk = ~sys_clk;
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic tick(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic set_brake(logic v);
    @(negedge sys_clk);
    bwr = 1'b1;
    bwd = v;
    @(negedge sys_clk);
    bwr = 1'b0;
  endtask
  task automatic clear();
    @(negedge sys_clk);
    clr = 1'b1;
    @(negedge sys_clk);
    clr = 1'b0;
    tick(3);
  endtask
  // Address byte, then one status byte ended by NACK when a read is acknowledged
  task automatic frame(logic [7:0] a, logic ack_exp);
    i_lead.start();
    i_lead.byte_io(a, 1'b1, rx, ar);
    chk("addr ack", {7'h00, ack_exp}, {7'h00, !ar});
    if (a[0] && !ar) begin
      i_lead.byte_io(8'hFF, 1'b1, rx, ar);
    end
    i_lead.stop();
    // Back onto the falling edge so the next stimulus stays aligned
    @(negedge sys_clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8000) @(posedge sys_clk);
    bad_count++;
    results();
  end
  initial begin
    {sys_clk, rst_b, sleep_input_n, oe, oc_sel, tsd_sel, clr, bwr, bwd} = 9'h000;
    det = '0;
    up_pin = 2'h1;
    lo_pin = 2'h2;
    bad_count = 0;
    check_count = 0;
    tick(20);
    rst_b = 1'b1;
    tick(5);
    chk("addr_code", 8'h05, addr_code);
    up_pin = 2'h0;
    lo_pin = 2'h0;
    tick(5);
    chk("addr_code", 8'h05, addr_code);
    chk("fault pin", 8'h01, fault_pin);
    chk("brake enable", 8'h01, brake_en);
    sleep_input_n = 1'b1;
    oe = 1'b1;
    tick(WAKE / 2);
    chk("bridge", 8'h00, bridge);
    tick(WAKE);
    chk("bridge", 8'h01, bridge);
    oe = 1'b0;
    tick(3);
    chk("bridge", 8'h00, bridge);
    det.ov = 1'b1;
    tick(5);
    chk("brake", 8'h01, brake);
    chk("status", 8'h02, status);
    chk("fault pin", 8'h01, fault_pin);
    oe = 1'b1;
    tick(5);
    chk("status", 8'h00, status);
    oe = 1'b0;
    set_brake(1'b0);
    tick(5);
    chk("brake enable", 8'h00, brake_en);
    chk("brake", 8'h00, brake);
    set_brake(1'b1);
    det.ov = 1'b0;
    tick(5);
    chk("brake", 8'h00, brake);
    oe = 1'b1;
    tick(3);
    det.oc = 1'b1;
    tick(5);
    det.oc = 1'b0;
    chk("bridge", 8'h00, bridge);
    chk("fault pin", 8'h00, fault_pin);
    chk("status", 8'h0C, status);
    tick(RTY + 10);
    chk("bridge", 8'h00, bridge);
    clear();
    chk("bridge", 8'h01, bridge);
    chk("fault pin", 8'h01, fault_pin);
    oc_sel = 1'b1;
    det.oc = 1'b1;
    tick(5);
    chk("bridge", 8'h00, bridge);
    tick(RTY / 2);
    chk("fault pin", 8'h00, fault_pin);
    // Overcurrent still present after the interval: the cycle repeats
    tick(RTY);
    chk("fault pin", 8'h00, fault_pin);
    det.oc = 1'b0;
    tick(RTY + 10);
    chk("bridge", 8'h01, bridge);
    chk("fault pin", 8'h01, fault_pin);
    oc_sel = 1'b0;
    clear();
    tsd_sel = 1'b1;
    det.ot = 1'b1;
    tick(5);
    chk("bridge", 8'h00, bridge);
    chk("status", 8'h09, status);
    det.ot = 1'b0;
    tick(5);
    chk("bridge", 8'h01, bridge);
    chk("status", 8'h01, status);
    chk("fault pin", 8'h01, fault_pin);
    frame(8'h6B, 1'b1);
    chk("read byte", 8'h04, rx);
    clear();
    chk("status", 8'h00, status);
    tsd_sel = 1'b0;
    det.ot = 1'b1;
    tick(5);
    det.ot = 1'b0;
    tick(5);
    chk("bridge", 8'h00, bridge);
    clear();
    chk("bridge", 8'h01, bridge);
    frame(8'h6A, 1'b1);
    frame(8'h00, 1'b0);
    frame(8'h60, 1'b0);
    frame(8'h6D, 1'b0);
    // Sleep entry must wait out the full delay, not the first low sample
    set_brake(1'b0);
    sleep_input_n = 1'b0;
    tick(SLP / 2);
    chk("bridge", 8'h01, bridge);
    tick(SLP);
    chk("bridge", 8'h00, bridge);
    chk("brake enable", 8'h00, brake_en);
    det.ov = 1'b1;
    tick(5);
    chk("brake", 8'h00, brake);
    set_brake(1'b1);
    tick(3);
    chk("brake enable", 8'h01, brake_en);
    chk("brake", 8'h01, brake);
    det.hc = 1'b1;
    tick(5);
    chk("brake", 8'h00, brake);
    results();
  end
endmodule
